/* File: boot_sideband_pkg.sv */
`default_nettype none
package boot_sideband_pkg;
  // Timing
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned SUPPLY_SETTLE_US  = 100;
  localparam int unsigned SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_US * CLK_MHZ;
  localparam int unsigned SETTLE_CNT_W      = 16;
  // I2C target
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h38;
  // Status byte field positions
  localparam int unsigned ST_CONNECTED = 0;
  localparam int unsigned ST_FLIPPED   = 1;
  localparam int unsigned ST_USB3      = 2;
  localparam int unsigned ST_DP        = 3;
  localparam int unsigned ST_PARTNER   = 4;
  localparam int unsigned ST_CFG_DONE  = 5;
  // Capability sets, voltage in 50 mV units, current in 10 mA units
  localparam int unsigned SRC_CAP_COUNT  = 1;
  localparam int unsigned SINK_CAP_COUNT = 4;
  localparam logic [9:0] SRC_V0  = 10'h064;
  localparam logic [9:0] SRC_I0  = 10'h12C;
  localparam logic [9:0] SNK_V0  = 10'h064;
  localparam logic [9:0] SNK_V1  = 10'h0B4;
  localparam logic [9:0] SNK_V2  = 10'h12C;
  localparam logic [9:0] SNK_V3  = 10'h190;
  localparam logic [9:0] SNK_I   = 10'h12C;
  localparam logic [9:0] SNK_I3  = 10'h1F4;
  // Flash loader
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int unsigned CFG_BYTES_DEF = 16;
  typedef enum logic [1:0] {LD_IDLE, LD_CMD, LD_DATA, LD_DONE} load_state_t;
endpackage
`default_nettype wire

/* File: i2c_status_target.sv */
`timescale 1ns/1ns
`default_nettype none
// Read-only I2C target returning one status byte at a fixed address
module i2c_status_target (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_out,
  // Data
  input  wire logic [7:0] status_in,
  output logic            read_done_out
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_SEND, T_MACK} tgt_state_t;
  tgt_state_t state_q;
  logic       scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start    = scl_in & sda_q & ~sda_in;
  wire stop     = scl_in & ~sda_q & sda_in;
  // Address in the upper seven bits, read flag in the lowest
  wire addr_hit = (sh_q[7:1] == boot_sideband_pkg::I2C_TARGET_ADDR) & sh_q[0];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= T_IDLE; scl_q <= 1'b1; sda_q <= 1'b1;
      bit_q <= 4'h0; sh_q <= 8'h00; sda_oe_out <= 1'b0; read_done_out <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      read_done_out <= 1'b0;
      if (start) begin
        state_q <= T_ADDR; bit_q <= 4'h0; sda_oe_out <= 1'b0;
      end else if (stop) begin
        state_q <= T_IDLE; sda_oe_out <= 1'b0;
      end else begin
        case (state_q)
          T_ADDR: if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_in};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            // Only reads are answered; writes and foreign addresses are ignored
            if (addr_hit) begin
              sda_oe_out <= 1'b1; state_q <= T_ACK;
            end else state_q <= T_IDLE;
          end
          T_ACK: if (scl_fall) begin
            sh_q <= status_in; bit_q <= 4'h0;
            sda_oe_out <= ~status_in[7]; state_q <= T_SEND;
          end
          T_SEND: if (scl_fall) begin
            if (bit_q == 4'h7) begin
              sda_oe_out <= 1'b0; state_q <= T_MACK;
            end else begin
              sda_oe_out <= ~sh_q[6]; sh_q <= {sh_q[6:0], 1'b0}; bit_q <= bit_q + 4'h1;
            end
          end
          T_MACK: if (scl_rise) begin
            read_done_out <= 1'b1;
            state_q <= sda_in ? T_IDLE : T_MACK;
            if (!sda_in) begin sh_q <= status_in; end
          end else if (scl_fall && state_q == T_MACK) begin
            sda_oe_out <= ~sh_q[7]; bit_q <= 4'h0; state_q <= T_SEND;
          end
          default: state_q <= T_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: partner_controller_boot_sideband.sv */
`timescale 1ns/1ns
`default_nettype none
module partner_controller_boot_sideband #(
  parameter int unsigned SETTLE_CYCLES = boot_sideband_pkg::SUPPLY_SETTLE_CYC,
  parameter int unsigned CFG_BYTES     = boot_sideband_pkg::CFG_BYTES_DEF
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Shared SPI flash
  output logic            flash_cs_n_out,
  output logic            flash_sck_out,
  output logic            flash_mosi_out,
  input  wire logic       flash_miso_in,
  output logic [7:0]      cfg_byte_out,
  output logic            cfg_byte_valid_out,
  output logic            cfg_done_out,
  // Partner reset and rail
  input  wire logic       partner_3v3_rail_in,
  input  wire logic       boot_hold_in,
  output logic            partner_reset_line_n_out,
  // Connection state from port logic
  input  wire logic       conn_resolved_in,
  input  wire logic       conn_flipped_in,
  input  wire logic       conn_usb3_in,
  input  wire logic       conn_dp_in,
  input  wire logic       conn_partner_in,
  // Partner interrupt and I2C
  output logic            partner_irq_n_out,
  input  wire logic       i2c_scl_in,
  input  wire logic       i2c_sda_in,
  output logic            i2c_sda_oe_out,
  // Mux events
  output logic            flip_ctl_out,
  output logic            usb3_lane_ctl_out,
  output logic            dp_lane_ctl_out,
  output logic            path_a_select_out,
  output logic            path_b_select_out,
  output logic            path_a_enable_out,
  output logic            path_b_enable_out,
  // Capabilities
  output logic [19:0]     src_cap_out,
  output logic [79:0]     sink_cap_out
);
  // Loader state and flash shift path, settle counter, connection and interrupt state, target wires
  boot_sideband_pkg::load_state_t ld_q;
  logic [5:0]  bit_q;
  logic [15:0] byte_q;
  logic [7:0]  sh_q;
  logic        sck_div_q;
  logic [boot_sideband_pkg::SETTLE_CNT_W-1:0] settle_q;
  logic [4:0]  conn_q;
  logic        irq_pend_q;
  logic        read_done;
  logic        sda_oe;

  // Flash clock runs at a quarter of clk_in to leave margin on the shared lines
  wire sck_edge  = sck_div_q;
  wire cmd_last  = bit_q == 6'd31;
  wire byte_last = byte_q == 16'(CFG_BYTES - 1);
  wire settled   = settle_q == boot_sideband_pkg::SETTLE_CNT_W'(SETTLE_CYCLES);
  wire release_ok = cfg_done_out & partner_3v3_rail_in & settled & ~boot_hold_in;
  wire mux_live  = cfg_done_out & conn_resolved_in;
  wire [4:0] conn_now = {conn_partner_in, conn_dp_in, conn_usb3_in, conn_flipped_in, conn_resolved_in};
  // Status uses the registered connection so it matches what raised the interrupt
  wire [7:0] status_byte = {2'b00, cfg_done_out, conn_q[4], conn_q[3], conn_q[2], conn_q[1], conn_q[0]};
  // Event levels are gated so the muxes never see a half-loaded state
  wire flip_d    = mux_live & conn_flipped_in;
  wire usb3_d    = mux_live & conn_usb3_in;
  wire dp_d      = mux_live & conn_dp_in;
  wire partner_d = mux_live & conn_partner_in;

  // Flash: read command plus zero address, then CFG_BYTES of data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ld_q <= boot_sideband_pkg::LD_IDLE;
      bit_q <= 6'd0;
      byte_q <= 16'h0000;
      sh_q <= 8'h00;
      sck_div_q <= 1'b0;
      flash_cs_n_out <= 1'b1;
      flash_sck_out <= 1'b0;
      flash_mosi_out <= 1'b0;
      cfg_byte_out <= 8'h00;
      cfg_byte_valid_out <= 1'b0;
      cfg_done_out <= 1'b0;
    end else begin
      cfg_byte_valid_out <= 1'b0;
      sck_div_q <= ~sck_div_q;
      case (ld_q)
        boot_sideband_pkg::LD_IDLE: begin
          flash_cs_n_out <= 1'b0;
          flash_mosi_out <= boot_sideband_pkg::FLASH_READ_CMD[7];
          ld_q <= boot_sideband_pkg::LD_CMD;
        end
        // Next command bit is set up on the falling flash clock edge
        boot_sideband_pkg::LD_CMD: if (sck_edge) begin
          flash_sck_out <= ~flash_sck_out;
          if (flash_sck_out) begin
            bit_q <= bit_q + 6'd1;
            if (cmd_last) begin
              bit_q <= 6'd0;
              ld_q <= boot_sideband_pkg::LD_DATA;
            end
            flash_mosi_out <= (bit_q < 6'd7) ? boot_sideband_pkg::FLASH_READ_CMD[3'(6 - bit_q)] : 1'b0;
          end
        end
        // Data is taken as the flash clock rises, settled since the last fall
        boot_sideband_pkg::LD_DATA: if (sck_edge) begin
          flash_sck_out <= ~flash_sck_out;
          if (!flash_sck_out) begin
            sh_q <= {sh_q[6:0], flash_miso_in};
            bit_q <= bit_q + 6'd1;
            if (bit_q[2:0] == 3'd7) begin
              cfg_byte_out <= {sh_q[6:0], flash_miso_in};
              cfg_byte_valid_out <= 1'b1;
              byte_q <= byte_q + 16'h0001;
              if (byte_last) begin
                ld_q <= boot_sideband_pkg::LD_DONE;
              end
            end
          end
        end
        boot_sideband_pkg::LD_DONE: begin
          // Bus is released so the partner can fetch its firmware next
          flash_cs_n_out <= 1'b1;
          flash_sck_out <= 1'b0;
          cfg_done_out <= 1'b1;
        end
        default: ld_q <= boot_sideband_pkg::LD_IDLE;
      endcase
    end
  end

  // Settle counter restarts whenever the rail drops
  // A rail glitch therefore costs the full settle time again, which is the safe side
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_q <= '0;
      partner_reset_line_n_out <= 1'b0;
    end else begin
      if (!partner_3v3_rail_in) begin
        settle_q <= '0;
      end else if (!settled) begin
        settle_q <= settle_q + 1'b1;
      end
      partner_reset_line_n_out <= release_ok;
    end
  end

  // Interrupt on any change of the five connection inputs after load done; cleared when the partner reads status
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conn_q <= 5'h00;
      irq_pend_q <= 1'b0;
      partner_irq_n_out <= 1'b1;
    end else begin
      conn_q <= conn_now;
      // A new change wins over a clear in the same cycle so no event is lost
      if (cfg_done_out && conn_now != conn_q) begin
        irq_pend_q <= 1'b1;
      end else if (read_done) begin
        irq_pend_q <= 1'b0;
      end
      partner_irq_n_out <= ~irq_pend_q;
    end
  end

  i2c_status_target u_target (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .scl_in        (i2c_scl_in),
    .sda_in        (i2c_sda_in),
    .sda_oe_out    (sda_oe),
    .status_in     (status_byte),
    .read_done_out (read_done)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      i2c_sda_oe_out <= 1'b0;
      flip_ctl_out <= 1'b0;
      usb3_lane_ctl_out <= 1'b0;
      dp_lane_ctl_out <= 1'b0;
      path_a_select_out <= 1'b0;
      path_b_select_out <= 1'b0;
      path_a_enable_out <= 1'b0;
      path_b_enable_out <= 1'b0;
      src_cap_out <= 20'h00000;
      sink_cap_out <= '0;
    end else begin
      i2c_sda_oe_out <= sda_oe;
      flip_ctl_out <= flip_d;
      usb3_lane_ctl_out <= usb3_d;
      dp_lane_ctl_out <= dp_d;
      path_a_select_out <= flip_d;
      path_b_select_out <= flip_d;
      path_a_enable_out <= dp_d;
      path_b_enable_out <= partner_d;
      src_cap_out <= {boot_sideband_pkg::SRC_V0, boot_sideband_pkg::SRC_I0};
      sink_cap_out <= {boot_sideband_pkg::SNK_V3, boot_sideband_pkg::SNK_I3,
                       boot_sideband_pkg::SNK_V2, boot_sideband_pkg::SNK_I,
                       boot_sideband_pkg::SNK_V1, boot_sideband_pkg::SNK_I,
                       boot_sideband_pkg::SNK_V0, boot_sideband_pkg::SNK_I};
    end
  end
endmodule
`default_nettype wire

/* File: flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Serial flash answering a plain read; data byte k is 8'h5A + 8'h11 * k
module flash_model (
  // Flash pins
  input  wire logic cs_n_in,
  input  wire logic sck_in,
  input  wire logic mosi_in,
  output logic      miso_out
);
  logic [31:0] hdr_q = 32'h0000_0000;
  logic        bit_q = 1'b0;
  int          n_bits = 0;
  wire  logic [7:0] byte_w = 8'h5A + 8'h11 * 8'((n_bits - 32) / 8);
  // Command and address shift in on rising edges
  always @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      n_bits <= 0;
    end else begin
      if (n_bits < 32) hdr_q <= {hdr_q[30:0], mosi_in};
      n_bits <= n_bits + 1;
    end
  end
  // Data moves on falling edges so it is settled at the next rising edge
  always @(negedge sck_in) if (!cs_n_in && n_bits >= 32) bit_q <= byte_w[7 - (n_bits - 32) % 8];
  // Deselected: inverse of the last bit, so a stale level never passes
  assign miso_out = cs_n_in ? ~bit_q : bit_q;
endmodule
`default_nettype wire

/* File: boot_sideband_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module boot_sideband_sva #(parameter int unsigned SETTLE_CYCLES = 20) (
  // Clock, reset and load
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        cfg_done_out,
  // Partner reset and interrupt
  input wire logic        partner_3v3_rail_in,
  input wire logic        boot_hold_in,
  input wire logic        partner_reset_line_n_out,
  input wire logic        partner_irq_n_out,
  // Connection
  input wire logic        conn_resolved_in,
  input wire logic        conn_flipped_in,
  input wire logic        conn_usb3_in,
  input wire logic        conn_dp_in,
  input wire logic        conn_partner_in,
  // Mux events and capabilities
  input wire logic        flip_ctl_out,
  input wire logic        usb3_lane_ctl_out,
  input wire logic        dp_lane_ctl_out,
  input wire logic        path_a_select_out,
  input wire logic        path_b_select_out,
  input wire logic        path_a_enable_out,
  input wire logic        path_b_enable_out,
  input wire logic [19:0] src_cap_out,
  input wire logic [79:0] sink_cap_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic [4:0] conn_w = {conn_partner_in, conn_dp_in, conn_usb3_in, conn_flipped_in, conn_resolved_in};
  wire logic [6:0] mux_w = {flip_ctl_out, usb3_lane_ctl_out, dp_lane_ctl_out, path_a_select_out,
                            path_b_select_out, path_a_enable_out, path_b_enable_out};
  wire logic [6:0] want_w = {conn_flipped_in, conn_usb3_in, conn_dp_in, conn_flipped_in, conn_flipped_in,
                             conn_dp_in, conn_partner_in};
  wire logic       live_w = cfg_done_out & conn_resolved_in;
  logic [15:0]     rail_cnt_q;
  // Consecutive cycles with the partner rail up, saturating
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) rail_cnt_q <= 16'h0000;
    else rail_cnt_q <= !partner_3v3_rail_in ? 16'h0000 : rail_cnt_q + 16'(rail_cnt_q != 16'hFFFF);
  reset_hold_a: assert property (!cfg_done_out |-> !partner_reset_line_n_out)
    else $error("partner reset released before load done");
  rail_gate_a: assert property (!partner_3v3_rail_in || boot_hold_in |=> !partner_reset_line_n_out)
    else $error("partner reset released without rail or under hold");
  settle_wait_a: assert property ($rose(partner_reset_line_n_out) |-> rail_cnt_q >= SETTLE_CYCLES)
    else $error("partner reset released before settle time");
  mux_idle_a: assert property (!live_w |=> mux_w == 7'h00)
    else $error("mux event active while not resolved");
  mux_follow_a: assert property (live_w |=> mux_w == $past(want_w))
    else $error("mux events do not follow connection");
  irq_idle_a: assert property (!cfg_done_out |-> partner_irq_n_out)
    else $error("partner interrupt before load done");
  irq_raise_a: assert property (cfg_done_out && $changed(conn_w) |-> ##[1:3] !partner_irq_n_out)
    else $error("no partner interrupt after connection change");
  caps_fixed_a: assert property ($past(rst_b_in) |-> src_cap_out == 20'h1912C &&
    sink_cap_out == {10'h190, 10'h1F4, 10'h12C, 10'h12C, 10'h0B4, 10'h12C, 10'h064, 10'h12C})
    else $error("capability sets wrong");
endmodule
bind partner_controller_boot_sideband boot_sideband_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) sva_u (
  .clk_in, .rst_b_in, .cfg_done_out, .partner_3v3_rail_in, .boot_hold_in, .partner_reset_line_n_out,
  .partner_irq_n_out, .conn_resolved_in, .conn_flipped_in, .conn_usb3_in, .conn_dp_in, .conn_partner_in,
  .flip_ctl_out, .usb3_lane_ctl_out, .dp_lane_ctl_out, .path_a_select_out, .path_b_select_out,
  .path_a_enable_out, .path_b_enable_out, .src_cap_out, .sink_cap_out);
`default_nettype wire

/* File: partner_controller_boot_sideband_test.sv */
`timescale 1ns/1ns
`default_nettype none
module partner_controller_boot_sideband_test;
  localparam int unsigned SETTLE = 20;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic rail_q = 1'b0;
  logic hold_q = 1'b1;
  logic [4:0] conn_q = 5'h00;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  wire logic cs_n_w, sck_w, mosi_w, miso_w, done_w, rst_n_w, irq_n_w, oe_w, cfg_v_w;
  wire logic [7:0] cfg_b_w;
  wire logic [6:0] mux_w;
  wire logic [19:0] src_w;
  wire logic [79:0] snk_w;
  // Open-drain bus with a pull-up
  wire logic sda_w = sda_q & ~oe_w;
  int error_cnt = 0;
  int total_checks = 0;
  int nbytes = 0;
  partner_controller_boot_sideband #(.SETTLE_CYCLES(SETTLE), .CFG_BYTES(2)) dut_u (
    .clk_in, .rst_b_in, .flash_cs_n_out(cs_n_w), .flash_sck_out(sck_w), .flash_mosi_out(mosi_w),
    .flash_miso_in(miso_w), .cfg_byte_out(cfg_b_w), .cfg_byte_valid_out(cfg_v_w), .cfg_done_out(done_w),
    .partner_3v3_rail_in(rail_q), .boot_hold_in(hold_q), .partner_reset_line_n_out(rst_n_w),
    .conn_resolved_in(conn_q[0]), .conn_flipped_in(conn_q[1]), .conn_usb3_in(conn_q[2]), .conn_dp_in(conn_q[3]),
    .conn_partner_in(conn_q[4]), .partner_irq_n_out(irq_n_w), .i2c_scl_in(scl_q), .i2c_sda_in(sda_w),
    .i2c_sda_oe_out(oe_w), .flip_ctl_out(mux_w[6]), .usb3_lane_ctl_out(mux_w[5]), .dp_lane_ctl_out(mux_w[4]),
    .path_a_select_out(mux_w[3]), .path_b_select_out(mux_w[2]), .path_a_enable_out(mux_w[1]),
    .path_b_enable_out(mux_w[0]), .src_cap_out(src_w), .sink_cap_out(snk_w));
  flash_model flash_u (.cs_n_in(cs_n_w), .sck_in(sck_w), .mosi_in(mosi_w), .miso_out(miso_w));
  always #2 clk_in = ~clk_in;
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [6:0] mux_exp(input logic [4:0] c);
    return c[0] ? {c[1], c[2], c[3], c[1], c[1], c[3], c[4]} : 7'h00;
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sda_q = b;
    wait_n(8);
    scl_q = 1'b1;
    wait_n(8);
    r = sda_w;
    scl_q = 1'b0;
  endtask
  task automatic i2c_read(input logic [6:0] addr, output logic ack, output logic [7:0] data);
    logic r;
    sda_q = 1'b0;
    wait_n(8);
    scl_q = 1'b0;
    for (int i = 7; i >= 0; i--) i2c_bit(i > 0 ? addr[i - 1] : 1'b1, r);
    i2c_bit(1'b1, ack);
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, data[i]);
    i2c_bit(1'b1, r);
    // Stop: data low under a low clock, clock up, then data up
    sda_q = 1'b0;
    wait_n(8);
    scl_q = 1'b1;
    wait_n(8);
    sda_q = 1'b1;
    wait_n(8);
  endtask
  always @(negedge clk_in) if (cfg_v_w === 1'b1) begin
    chk(cfg_b_w, 8'h5A + 8'h11 * nbytes[7:0]);
    nbytes++;
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    logic ack;
    logic [7:0] data;
    int n;
    void'($urandom(16642));
    wait_n(12);
    rst_b_in = 1'b1;
    for (n = 0; done_w !== 1'b1 && n < 2000; n++) wait_n(1);
    hold_q = 1'b0;
    wait_n(40);
    chk({nbytes, flash_u.hdr_q, rst_n_w}, {32'd2, 32'h0300_0000, 1'b0});
    rail_q = 1'b1;
    for (n = 0; rst_n_w !== 1'b1 && n < 100; n++) wait_n(1);
    chk(n >= SETTLE && n <= SETTLE + 2, 1'b1);
    hold_q = 1'b1;
    wait_n(3);
    chk(rst_n_w, 1'b0);
    hold_q = 1'b0;
    for (int k = 0; k < 40; k++) begin
      conn_q = k == 0 ? 5'h1E : 5'($urandom());
      wait_n(3);
      chk(mux_w, mux_exp(conn_q));
    end
    for (int k = 0; k < 2; k++) begin
      conn_q = {conn_q[4:1] ^ 4'h5, 1'b1};
      wait_n(4);
      chk(irq_n_w, 1'b0);
      i2c_read(7'h38, ack, data);
      chk({ack, data}, {4'h1, conn_q});
      wait_n(4);
      chk(irq_n_w, 1'b1);
    end
    i2c_read(7'h38 ^ 7'($urandom_range(1, 127)), ack, data);
    chk({ack, src_w, snk_w}, {1'b1, 20'h1912C, 80'h641F4_4B12C_2D12C_1912C});
    end_of_test();
  end
endmodule
`default_nettype wire
